// File: include/rss_defs.vh
// Purpose: constants for the rotate/subtract/skip execution block
// Assumes: 8-bit datapath, one instruction cycle per accepted request
// Notes: operation codes are local to this block
`ifndef RSS_DEFS_VH
`define RSS_DEFS_VH

// operation codes
`define RSS_OP_W 5
`define RSS_OP_ROT_LEFT_THRU_CARRY_TO_ACC 5'h00
`define RSS_OP_ROTATE_RIGHT 5'h01
`define RSS_OP_ROTATE_RIGHT_TO_ACC 5'h02
`define RSS_OP_ROTATE_RIGHT_THRU_CARRY 5'h03
`define RSS_OP_ROT_RIGHT_THRU_CARRY_TO_ACC 5'h04
`define RSS_OP_MINUS_WITH_BORROW 5'h05
`define RSS_OP_MINUS_WITH_BORROW_IMM 5'h06
`define RSS_OP_MINUS_WITH_BORROW_TO_MEM 5'h07
`define RSS_OP_DEC_SKIP_IF_ZERO 5'h08
`define RSS_OP_DEC_TO_ACC_SKIP_IF_ZERO 5'h09
`define RSS_OP_FILL_ONES 5'h0A
`define RSS_OP_BIT_SET 5'h0B
`define RSS_OP_INC_SKIP_IF_ZERO 5'h0C
`define RSS_OP_INC_TO_ACC_SKIP_IF_ZERO 5'h0D
`define RSS_OP_BIT_SKIP_IF_NONZERO 5'h0E
`define RSS_OP_SKIP_IF_NONZERO 5'h0F
`define RSS_OP_MINUS 5'h10
`define RSS_OP_MINUS_TO_MEM 5'h11
`define RSS_OP_MINUS_IMM 5'h12
`define RSS_OP_NIBBLE_EXCHANGE 5'h13
`define RSS_OP_NIBBLE_EXCHANGE_TO_ACC 5'h14

// flag vector positions
`define RSS_FLAG_W 6
`define RSS_FLG_CARRY 0
`define RSS_FLG_HALF_BORROW 1
`define RSS_FLG_ZERO 2
`define RSS_FLG_SIGNED_WRAP 3
`define RSS_FLG_SIGNED_BORROW 4
`define RSS_FLG_CHAINED_ZERO 5

// reset and fill values
`define RSS_ACC_RESET 8'h00
`define RSS_FLAGS_RESET 6'h00
`define RSS_FILL_VALUE 8'hFF

// a skip costs one extra instruction cycle
`define RSS_SKIP_DUMMY_CYCLES 2'h1

`endif

// File: rtl/rss_exec.v
// Purpose: rotate, subtract, fill, skip and nibble-exchange execution
// Assumes: memory operand and immediate valid while op_valid is high
// Notes: one result per accepted cycle; requests held off during a skip
//
// Behaviour
// - rotate left via carry into accumulator
// - rotate memory right, bit0 to bit7
// - rotate right into accumulator, no flags
// - rotate memory right via carry
// - rotate right via carry into accumulator
// - acc minus memory minus inverted carry
// - carry clear on negative, else set
// - acc minus immediate minus inverted carry
// - borrow subtract written back to memory
// - decrement memory, skip when zero
// - decrement into accumulator, skip when zero
// - skip inserts one dummy cycle
// - fill ones or set one bit
// - increment memory, skip when zero
// - increment into accumulator, skip when zero
// - skip when selected bit is one
// - rewrite byte, skip when nonzero
// - acc minus memory into accumulator
// - acc minus memory into memory
// - acc minus immediate, carry ignored
// - swap nibbles to memory or accumulator
// - subtracts update all six flags
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.vh"

module rss_exec (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // instruction request
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [7:0] mem_data,
  input wire [7:0] imm_data,
  input wire [2:0] bit_sel,
  // accumulator and status
  output reg [7:0] acc,
  output reg [5:0] flags,
  // data memory write-back
  output reg mem_wr,
  output reg [7:0] mem_wdata,
  // pipeline control
  output wire skip_flush,
  output wire exec_busy
);

  // result lands in the accumulator
  function writes_acc;
    input [4:0] op;
    begin
      case (op)
        `RSS_OP_ROT_LEFT_THRU_CARRY_TO_ACC,
        `RSS_OP_ROTATE_RIGHT_TO_ACC,
        `RSS_OP_ROT_RIGHT_THRU_CARRY_TO_ACC,
        `RSS_OP_MINUS_WITH_BORROW,
        `RSS_OP_MINUS_WITH_BORROW_IMM,
        `RSS_OP_DEC_TO_ACC_SKIP_IF_ZERO,
        `RSS_OP_INC_TO_ACC_SKIP_IF_ZERO,
        `RSS_OP_MINUS,
        `RSS_OP_MINUS_IMM,
        `RSS_OP_NIBBLE_EXCHANGE_TO_ACC: writes_acc = 1'h1;
        default: writes_acc = 1'h0;
      endcase
    end
  endfunction

  // result written back to data memory
  function writes_mem;
    input [4:0] op;
    begin
      case (op)
        `RSS_OP_ROTATE_RIGHT,
        `RSS_OP_ROTATE_RIGHT_THRU_CARRY,
        `RSS_OP_MINUS_WITH_BORROW_TO_MEM,
        `RSS_OP_DEC_SKIP_IF_ZERO,
        `RSS_OP_FILL_ONES,
        `RSS_OP_BIT_SET,
        `RSS_OP_INC_SKIP_IF_ZERO,
        `RSS_OP_SKIP_IF_NONZERO,
        `RSS_OP_MINUS_TO_MEM,
        `RSS_OP_NIBBLE_EXCHANGE: writes_mem = 1'h1;
        default: writes_mem = 1'h0;
      endcase
    end
  endfunction

  // subtract forms own the full flag set
  function is_sub;
    input [4:0] op;
    begin
      case (op)
        `RSS_OP_MINUS_WITH_BORROW,
        `RSS_OP_MINUS_WITH_BORROW_IMM,
        `RSS_OP_MINUS_WITH_BORROW_TO_MEM,
        `RSS_OP_MINUS,
        `RSS_OP_MINUS_TO_MEM,
        `RSS_OP_MINUS_IMM: is_sub = 1'h1;
        default: is_sub = 1'h0;
      endcase
    end
  endfunction

  // borrow forms chain carry and zero
  function uses_borrow;
    input [4:0] op;
    begin
      case (op)
        `RSS_OP_MINUS_WITH_BORROW,
        `RSS_OP_MINUS_WITH_BORROW_IMM,
        `RSS_OP_MINUS_WITH_BORROW_TO_MEM: uses_borrow = 1'h1;
        default: uses_borrow = 1'h0;
      endcase
    end
  endfunction

  // immediate operand instead of memory
  function uses_imm;
    input [4:0] op;
    begin
      case (op)
        `RSS_OP_MINUS_WITH_BORROW_IMM,
        `RSS_OP_MINUS_IMM: uses_imm = 1'h1;
        default: uses_imm = 1'h0;
      endcase
    end
  endfunction

  // one-hot mask of the selected bit
  wire [7:0] bit_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      localparam [2:0] POS = gi;
      assign bit_mask[gi] = (bit_sel == POS);
    end
  endgenerate

  // request accepted only outside a dummy cycle
  wire accept;
  wire skip_req;
  reg next_skip;
  assign accept = op_valid & ~exec_busy;
  assign skip_req = accept & next_skip;

  // shared subtractor operands
  wire [7:0] sub_rhs;
  wire sub_bin;
  wire sub_zin;
  wire [7:0] sub_diff;
  wire sub_c;
  wire sub_hb;
  wire sub_z;
  wire sub_sw;
  wire sub_sb;
  wire sub_cz;
  assign sub_rhs = uses_imm(op_code) ? imm_data : mem_data;
  // carry is an inverted borrow
  assign sub_bin = uses_borrow(op_code) ? ~flags[`RSS_FLG_CARRY] : 1'h0;
  // plain forms start a fresh zero chain
  assign sub_zin = uses_borrow(op_code) ? flags[`RSS_FLG_CHAINED_ZERO] : 1'h1;

  rss_subtractor u_sub (
    .minuend(acc),
    .subtrahend(sub_rhs),
    .borrow_in(sub_bin),
    .zero_in(sub_zin),
    .diff(sub_diff),
    .carry(sub_c),
    .half_borrow(sub_hb),
    .zero(sub_z),
    .signed_wrap(sub_sw),
    .signed_borrow(sub_sb),
    .chained_zero(sub_cz)
  );

  // wrapping step for the skip counters
  wire [7:0] mem_inc;
  wire [7:0] mem_dec;
  assign mem_inc = mem_data + 8'h01;
  assign mem_dec = mem_data - 8'h01;

  reg [7:0] next_result;
  reg next_carry;

  always @* begin
    next_result = mem_data;
    next_carry = flags[`RSS_FLG_CARRY];
    next_skip = 1'h0;
    case (op_code)
      `RSS_OP_ROT_LEFT_THRU_CARRY_TO_ACC: begin
        next_result = {mem_data[6:0], flags[`RSS_FLG_CARRY]};
        next_carry = mem_data[7];
      end
      `RSS_OP_ROTATE_RIGHT,
      `RSS_OP_ROTATE_RIGHT_TO_ACC: begin
        next_result = {mem_data[0], mem_data[7:1]};
      end
      `RSS_OP_ROTATE_RIGHT_THRU_CARRY,
      `RSS_OP_ROT_RIGHT_THRU_CARRY_TO_ACC: begin
        next_result = {flags[`RSS_FLG_CARRY], mem_data[7:1]};
        next_carry = mem_data[0];
      end
      `RSS_OP_MINUS_WITH_BORROW,
      `RSS_OP_MINUS_WITH_BORROW_IMM,
      `RSS_OP_MINUS_WITH_BORROW_TO_MEM,
      `RSS_OP_MINUS,
      `RSS_OP_MINUS_TO_MEM,
      `RSS_OP_MINUS_IMM: begin
        next_result = sub_diff;
        next_carry = sub_c;
      end
      `RSS_OP_DEC_SKIP_IF_ZERO,
      `RSS_OP_DEC_TO_ACC_SKIP_IF_ZERO: begin
        next_result = mem_dec;
        next_skip = (mem_dec == 8'h00);
      end
      `RSS_OP_FILL_ONES: begin
        next_result = `RSS_FILL_VALUE;
      end
      `RSS_OP_BIT_SET: begin
        next_result = mem_data | bit_mask;
      end
      `RSS_OP_INC_SKIP_IF_ZERO,
      `RSS_OP_INC_TO_ACC_SKIP_IF_ZERO: begin
        next_result = mem_inc;
        next_skip = (mem_inc == 8'h00);
      end
      `RSS_OP_BIT_SKIP_IF_NONZERO: begin
        next_skip = |(mem_data & bit_mask);
      end
      `RSS_OP_SKIP_IF_NONZERO: begin
        next_result = mem_data;
        next_skip = (mem_data != 8'h00);
      end
      `RSS_OP_NIBBLE_EXCHANGE,
      `RSS_OP_NIBBLE_EXCHANGE_TO_ACC: begin
        next_result = {mem_data[3:0], mem_data[7:4]};
      end
      default: begin
        next_result = mem_data;
      end
    endcase
  end

  reg [5:0] next_flags;

  always @* begin
    next_flags = flags;
    if (is_sub(op_code)) begin
      next_flags[`RSS_FLG_CARRY] = sub_c;
      next_flags[`RSS_FLG_HALF_BORROW] = sub_hb;
      next_flags[`RSS_FLG_ZERO] = sub_z;
      next_flags[`RSS_FLG_SIGNED_WRAP] = sub_sw;
      next_flags[`RSS_FLG_SIGNED_BORROW] = sub_sb;
      next_flags[`RSS_FLG_CHAINED_ZERO] = sub_cz;
    end else begin
      // rotates through carry touch carry only
      next_flags[`RSS_FLG_CARRY] = next_carry;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc <= `RSS_ACC_RESET;
      flags <= `RSS_FLAGS_RESET;
      mem_wr <= 1'h0;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr <= accept & writes_mem(op_code);
      if (accept) begin
        flags <= next_flags;
        if (writes_acc(op_code)) begin
          acc <= next_result;
        end
        if (writes_mem(op_code)) begin
          mem_wdata <= next_result;
        end
      end
    end
  end

  rss_skip_ctrl u_skip (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .skip_req(skip_req),
    .flush(skip_flush),
    .busy(exec_busy)
  );

endmodule // rss_exec

`default_nettype wire

// File: rtl/rss_skip_ctrl.v
// Purpose: turns a skip decision into a dummy pipeline cycle
// Assumes: skip_req is a one-cycle pulse with the completing instruction
// Notes: the fetched follower is discarded, not executed
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.vh"

module rss_skip_ctrl (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // control
  input wire skip_req,
  output reg flush,
  output reg busy
);

  reg [1:0] cnt;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 2'h0;
      flush <= 1'b0;
      busy <= 1'b0;
    end else if (skip_req) begin
      cnt <= `RSS_SKIP_DUMMY_CYCLES;
      flush <= 1'b1;
      busy <= 1'b1;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
      flush <= 1'b0;
      busy <= (cnt != 2'h1);
    end else begin
      flush <= 1'b0;
      busy <= 1'b0;
    end
  end

endmodule // rss_skip_ctrl

`default_nettype wire

// File: rtl/rss_subtractor.v
// Purpose: 8-bit subtract with borrow-in and full flag set
// Assumes: carry is an inverted borrow
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none

module rss_subtractor (
  // operands
  input wire [7:0] minuend,
  input wire [7:0] subtrahend,
  input wire borrow_in,
  input wire zero_in,
  // result
  output wire [7:0] diff,
  output wire carry,
  output wire half_borrow,
  output wire zero,
  output wire signed_wrap,
  output wire signed_borrow,
  output wire chained_zero
);

  wire [8:0] full;
  wire [4:0] low;
  wire [8:0] sdiff;

  assign full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
  // sign-extended difference tells the true signed outcome
  assign sdiff = {minuend[7], minuend} - {subtrahend[7], subtrahend} - {8'h00, borrow_in};
  assign diff = full[7:0];
  assign carry = ~full[8];
  assign half_borrow = ~low[4];
  assign zero = (full[7:0] == 8'h00);
  assign signed_wrap = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full[7]);
  assign signed_borrow = sdiff[8];
  // chained zero keeps a multi-byte result zero only if all bytes were
  assign chained_zero = zero & zero_in;

endmodule // rss_subtractor

`default_nettype wire

// File: test/rss_exec_tb.sv
// Purpose: rotates, subtract flags, fills, nibble swap and skip timing
// Assumes: carry is an inverted borrow
// Notes: results read at the falling edge after the taking edge
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.vh"
`define CHK(x, y) begin n_checks++; if ((x) !== (y)) begin bad_count++; \
  $display("BAD %0t mismatch", $time); end end
module rss_exec_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic op_valid = 1'b0;
  logic [4:0] op_code = 5'h00;
  logic [7:0] mem_data = 8'h00;
  logic [7:0] imm_data = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  wire [7:0] acc;
  wire [5:0] flags;
  wire mem_wr;
  wire [7:0] mem_wdata;
  wire skip_flush;
  wire exec_busy;
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  rss_exec uut (.clk_sys(clk_sys), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
    .mem_data(mem_data), .imm_data(imm_data), .bit_sel(bit_sel), .acc(acc), .flags(flags),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .skip_flush(skip_flush), .exec_busy(exec_busy));
  // request stands over one rising edge, then is withdrawn
  task automatic issue(input logic [4:0] op, input logic [7:0] m, input logic [7:0] im,
      input logic [2:0] bs);
    @(negedge clk_sys);
    op_valid = 1'b1;
    op_code = op;
    mem_data = m;
    imm_data = im;
    bit_sel = bs;
    @(negedge clk_sys);
    op_valid = 1'b0;
  endtask
  task automatic test_rotate();
    issue(`RSS_OP_ROT_LEFT_THRU_CARRY_TO_ACC, 8'h81, 8'h00, 3'h0);
    `CHK({acc, flags[`RSS_FLG_CARRY], mem_wr}, {8'h02, 1'b1, 1'b0})
    issue(`RSS_OP_ROTATE_RIGHT, 8'h01, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata, flags}, {1'b1, 8'h80, 6'h01})
    issue(`RSS_OP_ROTATE_RIGHT_TO_ACC, 8'h0A, 8'h00, 3'h0);
    `CHK({acc, mem_wr, flags}, {8'h05, 1'b0, 6'h01})
    issue(`RSS_OP_ROTATE_RIGHT_THRU_CARRY, 8'h02, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata, acc, flags[`RSS_FLG_CARRY]}, {1'b1, 8'h81, 8'h05, 1'b0})
    issue(`RSS_OP_ROT_RIGHT_THRU_CARRY_TO_ACC, 8'h03, 8'h00, 3'h0);
    `CHK({acc, flags[`RSS_FLG_CARRY], mem_wr}, {8'h01, 1'b1, 1'b0})
  endtask
  task automatic test_minus();
    issue(`RSS_OP_ROTATE_RIGHT_TO_ACC, 8'h0A, 8'h00, 3'h0);
    issue(`RSS_OP_MINUS, 8'h03, 8'h00, 3'h0);
    `CHK({acc, flags}, {8'h02, 6'h03})
    issue(`RSS_OP_MINUS_TO_MEM, 8'h05, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata, acc, flags}, {1'b1, 8'hFD, 8'h02, 6'h10})
    `CHK(flags[`RSS_FLG_CARRY], 1'b0)
    issue(`RSS_OP_MINUS_IMM, 8'h00, 8'h02, 3'h0);
    `CHK({acc, flags, mem_wr}, {8'h00, 6'h27, 1'b0})
    issue(`RSS_OP_ROTATE_RIGHT_TO_ACC, 8'h01, 8'h00, 3'h0);
    issue(`RSS_OP_MINUS, 8'h01, 8'h00, 3'h0);
    `CHK({acc, flags}, {8'h7F, 6'h19})
  endtask
  task automatic test_borrow();
    issue(`RSS_OP_ROTATE_RIGHT_TO_ACC, 8'h0A, 8'h00, 3'h0);
    issue(`RSS_OP_MINUS_WITH_BORROW, 8'h05, 8'h00, 3'h0);
    `CHK({acc, flags}, {8'h00, 6'h07})
    issue(`RSS_OP_MINUS_WITH_BORROW_IMM, 8'h00, 8'h01, 3'h0);
    `CHK({acc, flags}, {8'hFF, 6'h10})
    issue(`RSS_OP_MINUS_WITH_BORROW, 8'h05, 8'h00, 3'h0);
    `CHK({acc, flags}, {8'hF9, 6'h13})
    issue(`RSS_OP_MINUS_WITH_BORROW_TO_MEM, 8'h01, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata, acc, flags}, {1'b1, 8'hF8, 8'hF9, 6'h13})
    `CHK(flags[`RSS_FLG_CARRY], 1'b1)
  endtask
  task automatic test_skip();
    int n;
    @(negedge clk_sys);
    op_valid = 1'b1;
    op_code = `RSS_OP_DEC_SKIP_IF_ZERO;
    mem_data = 8'h01;
    @(negedge clk_sys);
    `CHK({mem_wr, mem_wdata, skip_flush, exec_busy}, {1'b1, 8'h00, 1'b1, 1'b1})
    op_code = `RSS_OP_FILL_ONES;
    @(negedge clk_sys);
    op_valid = 1'b0;
    `CHK({mem_wr, skip_flush, exec_busy}, 3'h0)
    `CHK(flags, 6'h13)
    issue(`RSS_OP_DEC_TO_ACC_SKIP_IF_ZERO, 8'h05, 8'h00, 3'h0);
    `CHK({acc, mem_wr, skip_flush}, {8'h04, 1'b0, 1'b0})
    issue(`RSS_OP_DEC_TO_ACC_SKIP_IF_ZERO, 8'h01, 8'h00, 3'h0);
    `CHK({acc, mem_wr, skip_flush}, {8'h00, 1'b0, 1'b1})
    @(negedge clk_sys);
    `CHK(skip_flush, 1'b0)
    issue(`RSS_OP_INC_SKIP_IF_ZERO, 8'hFF, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata, skip_flush}, {1'b1, 8'h00, 1'b1})
    issue(`RSS_OP_INC_TO_ACC_SKIP_IF_ZERO, 8'h41, 8'h00, 3'h0);
    `CHK({acc, mem_wr, skip_flush}, {8'h42, 1'b0, 1'b0})
    issue(`RSS_OP_INC_TO_ACC_SKIP_IF_ZERO, 8'hFF, 8'h00, 3'h0);
    `CHK({acc, mem_wr, skip_flush}, {8'h00, 1'b0, 1'b1})
    issue(`RSS_OP_BIT_SKIP_IF_NONZERO, 8'h08, 8'h00, 3'h3);
    `CHK({mem_wr, skip_flush}, 2'h1)
    n = 0;
    while (exec_busy !== 1'b0 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 4)
      bad_count++;
    `CHK(n, 1)
    issue(`RSS_OP_BIT_SKIP_IF_NONZERO, 8'h08, 8'h00, 3'h2);
    `CHK({mem_wr, skip_flush}, 2'h0)
    issue(`RSS_OP_SKIP_IF_NONZERO, 8'h00, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata, skip_flush}, {1'b1, 8'h00, 1'b0})
    issue(`RSS_OP_SKIP_IF_NONZERO, 8'h5A, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata, skip_flush}, {1'b1, 8'h5A, 1'b1})
    `CHK(flags, 6'h13)
  endtask
  task automatic test_fill();
    issue(`RSS_OP_FILL_ONES, 8'h12, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata}, {1'b1, 8'hFF})
    issue(`RSS_OP_BIT_SET, 8'h00, 8'h00, 3'h5);
    `CHK({mem_wr, mem_wdata}, {1'b1, 8'h20})
    issue(`RSS_OP_BIT_SET, 8'h81, 8'h00, 3'h1);
    `CHK({mem_wr, mem_wdata}, {1'b1, 8'h83})
    issue(`RSS_OP_NIBBLE_EXCHANGE, 8'h3C, 8'h00, 3'h0);
    `CHK({mem_wr, mem_wdata}, {1'b1, 8'hC3})
    issue(`RSS_OP_NIBBLE_EXCHANGE_TO_ACC, 8'hA5, 8'h00, 3'h0);
    `CHK({acc, mem_wr}, {8'h5A, 1'b0})
    `CHK(flags, 6'h13)
  endtask
  task automatic complete_run();
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    test_rotate();
    test_minus();
    test_borrow();
    test_skip();
    test_fill();
    complete_run();
  end
endmodule // rss_exec_tb
`default_nettype wire

// File: test/rss_skip_assertions.sv
// Purpose: skip timing, write-back and flag checks on the top ports
// Assumes: requests change only off the rising edge
// Notes: bound to the execution block
`timescale 1ns/10ps
`default_nettype none
`include "rss_defs.vh"
module rss_skip_chk (
  // watched top ports
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [7:0] mem_data,
  input wire logic [5:0] flags,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic skip_flush,
  input wire logic exec_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_skip_gives_flush: assert property ((op_valid && !exec_busy &&
    op_code == `RSS_OP_DEC_SKIP_IF_ZERO && mem_data == 8'h01) |=> skip_flush)
    else $error("no flush after skip");
  a_flush_one_cycle: assert property (skip_flush |=> !skip_flush)
    else $error("flush held too long");
  a_flush_holds_off: assert property (skip_flush |-> exec_busy)
    else $error("flush without hold-off");
  a_refused_no_write: assert property ((op_valid && exec_busy) |=> !mem_wr)
    else $error("request taken in dummy cycle");
  a_rotate_keeps_flags: assert property ((op_valid && !exec_busy &&
    op_code == `RSS_OP_ROTATE_RIGHT) |=> (flags == $past(flags)))
    else $error("rotate right changed flags");
  a_acc_rotate_nowrite: assert property ((op_valid && !exec_busy &&
    op_code == `RSS_OP_ROTATE_RIGHT_TO_ACC) |=> !mem_wr)
    else $error("accumulator rotate wrote memory");
  a_fill_writes_ones: assert property ((op_valid && !exec_busy &&
    op_code == `RSS_OP_FILL_ONES) |=> (mem_wr && mem_wdata == 8'hFF))
    else $error("fill did not write ones");
endmodule // rss_skip_chk
bind rss_exec rss_skip_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .op_valid(op_valid),
  .op_code(op_code), .mem_data(mem_data), .flags(flags), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .skip_flush(skip_flush), .exec_busy(exec_busy));
`default_nettype wire
